// [rtl/pirl_top.sv]
// Front panel interrupt latch merged with system and local nested controllers
`timescale 1ns/1ps
module pirl_top
  import pirl_pkg::*;
#(
  parameter int LONG_CYCLES = LONG_DEBOUNCE_CYCLES
)
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [7:0] panel_switch_in,
  input wire logic phase_one_clk_in,
  input wire logic [7:0] bus_request_lines_n_in,
  input wire logic [6:0] local_request_in,
  input wire logic interrupt_acknowledge_n_in,
  input wire logic data_bus_in_strobe_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_rd_in,
  input wire logic cpu_sel_system_in,
  input wire logic cpu_sel_local_in,
  input wire logic cpu_addr0_in,
  input wire logic [7:0] cpu_wdata_in,
  output logic group_select_out,
  output logic cascade_enable_out,
  output logic [7:0] panel_request_out,
  output logic int_request_out,
  output logic [7:0] ack_data_out,
  output logic ack_data_drive_out,
  output logic [7:0] cpu_rdata_out
);

  localparam int SHORT_WAIT = SHORT_DEBOUNCE_CYCLES + 1;

  // ---------------------------------------------------------------
  // Switch encoder and debounce
  // ---------------------------------------------------------------
  pirl_db_state_t db_state_reg;
  pirl_db_state_t db_state_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;
  logic captured_reg;
  logic captured_next;
  logic any_active;
  logic [2:0] switch_code;
  logic timer_done;
  logic debounce_set;
  logic panel_en;

  assign any_active = |panel_switch_in;
  assign switch_code = pirl_prio(panel_switch_in);
  assign timer_done = (timer_reg == '0);
  // Debounce flip-flop is set from the second timer trigger until idle
  assign debounce_set = (db_state_reg == DB_SHORT) || (db_state_reg == DB_HOLD);

  always_comb
  begin
    db_state_next = db_state_reg;
    timer_next = timer_done ? timer_reg : timer_reg - 1'b1;
    unique case (db_state_reg)
      DB_IDLE:
      begin
        if (any_active)
        begin
          db_state_next = DB_LONG;
          timer_next = TIMER_W'(LONG_CYCLES - 1);
        end
      end
      DB_LONG:
      begin
        if (timer_done && any_active)
        begin
          db_state_next = DB_SHORT;
          timer_next = TIMER_W'(SHORT_DEBOUNCE_CYCLES - 1);
        end
        else if (timer_done)
        begin
          db_state_next = DB_IDLE;
        end
      end
      DB_SHORT:
      begin
        if (timer_done)
        begin
          db_state_next = DB_HOLD;
        end
      end
      DB_HOLD:
      begin
        if (!any_active)
        begin
          db_state_next = DB_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Acknowledge sequence tracking
  // ---------------------------------------------------------------
  logic interrupt_acknowledge_n_prev_reg;
  logic [1:0] ack_count_reg;
  logic [1:0] ack_count_next;
  logic [2:0] svc_vec_reg;
  logic interrupt_acknowledge_n_fall;
  logic ack_first;
  logic ack_second;
  logic [7:0] vec_low_byte;
  logic [7:0] ack_data_next;
  logic ack_drive_next;

  // Three acknowledge cycles per call; the count restarts on the next fall
  assign interrupt_acknowledge_n_fall = interrupt_acknowledge_n_prev_reg && !interrupt_acknowledge_n_in;
  assign ack_count_next = !interrupt_acknowledge_n_fall ? ack_count_reg :
                          (ack_count_reg == 2'h3) ? 2'h1 : ack_count_reg + 2'h1;
  assign ack_first = interrupt_acknowledge_n_fall && (ack_count_next == 2'h1);
  assign ack_second = (ack_count_reg == 2'h2) && !interrupt_acknowledge_n_in;
  // Spacing of eight puts the code in bits 3 to 5
  assign vec_low_byte = {VEC_BASE_BITS, svc_vec_reg, 3'h0};
  assign ack_drive_next = !interrupt_acknowledge_n_in && data_bus_in_strobe_in;
  assign ack_data_next = !ack_drive_next ? ack_data_out :
                         (ack_count_reg == 2'h1) ? CALL_OPCODE :
                         (ack_count_reg == 2'h2) ? vec_low_byte : VEC_HIGH_BYTE;

  // ---------------------------------------------------------------
  // Request latch with ID source multiplexer
  // ---------------------------------------------------------------
  logic [7:0] latch_next;
  logic [7:0] latch_bit;
  logic [2:0] latch_addr;
  logic latch_d;
  logic latch_en;
  logic [2:0] ack_code;

  // Bits 3 to 5 of the vector select the bit; a spacing of four would miss it
  assign ack_code = vec_low_byte[VEC_CODE_MSB:VEC_CODE_LSB];
  // Panel capture waits while an acknowledge owns the multiplexer
  assign panel_en = debounce_set && phase_one_clk_in && !captured_reg && !ack_second && any_active;
  assign latch_addr = ack_second ? ack_code : switch_code;
  assign latch_d = !ack_second;
  assign latch_en = ack_second ? (phase_one_clk_in && data_bus_in_strobe_in) : panel_en;
  assign latch_bit = 8'h01 << latch_addr;
  // Bits change only when enabled, so a set bit holds until cleared
  assign latch_next = !latch_en ? panel_request_out :
                      latch_d ? (panel_request_out | latch_bit) : (panel_request_out & ~latch_bit);
  assign captured_next = (db_state_next == DB_IDLE) ? 1'b0 : (captured_reg || panel_en);

  // ---------------------------------------------------------------
  // System and local controllers
  // ---------------------------------------------------------------
  logic [7:0] sys_req;
  logic [7:0] loc_req;
  logic sys_pend;
  logic [2:0] sys_pend_code;
  logic [2:0] sys_svc_code;
  logic [7:0] sys_isr;
  logic [7:0] sys_mask;
  logic [7:0] sys_irr;
  logic loc_pend;
  logic [2:0] loc_pend_code;
  logic [7:0] loc_isr;
  logic [7:0] loc_mask;
  logic sys_cmd_wr;
  logic loc_cmd_wr;
  logic loc_poll_rd;
  logic poll_armed_reg;

  // Panel bits and bus lines merge without telling them apart
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++)
    begin : g_merge
      if (gi == int'(CASCADE_LINE))
      begin : g_cascade
        assign sys_req[gi] = panel_request_out[gi] || !bus_request_lines_n_in[gi] || loc_pend;
      end
      else
      begin : g_plain
        assign sys_req[gi] = panel_request_out[gi] || !bus_request_lines_n_in[gi];
      end
    end
  endgenerate

  // Local line order: rx0, tx0, rx1, tx1, clock, parallel, I/O; line 7 unused
  assign loc_req = {1'b0, local_request_in};
  assign sys_cmd_wr = cpu_wr_in && cpu_sel_system_in && !cpu_addr0_in;
  assign loc_cmd_wr = cpu_wr_in && cpu_sel_local_in && !cpu_addr0_in;
  assign loc_poll_rd = cpu_rd_in && cpu_sel_local_in && !cpu_addr0_in && poll_armed_reg;

  pirl_nest_ctrl #(
    .MASK_INIT(SYS_MASK_RESET)
  ) u_sys_ctrl (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .req_in(sys_req),
    .mask_wr_in(cpu_wr_in && cpu_sel_system_in && cpu_addr0_in),
    .mask_data_in(cpu_wdata_in),
    .eoi_in(sys_cmd_wr && (cpu_wdata_in == CMD_EOI)),
    .grant_in(ack_first),
    .pend_out(sys_pend),
    .pend_code_out(sys_pend_code),
    .svc_code_out(sys_svc_code),
    .isr_out(sys_isr),
    .mask_out(sys_mask),
    .irr_out(sys_irr)
  );

  pirl_nest_ctrl #(
    .MASK_INIT(LOCAL_MASK_RESET)
  ) u_loc_ctrl (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .req_in(loc_req),
    .mask_wr_in(cpu_wr_in && cpu_sel_local_in && cpu_addr0_in),
    .mask_data_in(cpu_wdata_in),
    .eoi_in(loc_cmd_wr && (cpu_wdata_in == CMD_EOI)),
    .grant_in(loc_poll_rd),
    .pend_out(loc_pend),
    .pend_code_out(loc_pend_code),
    .svc_code_out(),
    .isr_out(loc_isr),
    .mask_out(loc_mask),
    .irr_out()
  );

  // ---------------------------------------------------------------
  // Processor status reads and commands
  // ---------------------------------------------------------------
  pirl_rsel_t rsel_reg;
  pirl_rsel_t rsel_next;
  logic poll_armed_next;
  logic [7:0] sys_status;
  logic [7:0] poll_byte;
  logic [7:0] loc_status;
  logic [7:0] rdata_next;

  assign rsel_next = !sys_cmd_wr ? rsel_reg :
                     (cpu_wdata_in == CMD_READ_IRR) ? RSEL_IRR :
                     (cpu_wdata_in == CMD_READ_ISR) ? RSEL_ISR :
                     (cpu_wdata_in == CMD_READ_SVC) ? RSEL_SVC : rsel_reg;
  // Status: pending lines, lines in service, or the code in service
  assign sys_status = (rsel_reg == RSEL_IRR) ? sys_irr :
                      (rsel_reg == RSEL_ISR) ? sys_isr : {5'h00, sys_svc_code};
  assign poll_byte = {loc_pend, 4'h0, loc_pend_code};
  assign loc_status = poll_armed_reg ? poll_byte : loc_isr;
  assign poll_armed_next = (loc_cmd_wr && (cpu_wdata_in == CMD_POLL)) ? 1'b1 :
                           (cpu_rd_in && cpu_sel_local_in && !cpu_addr0_in) ? 1'b0 : poll_armed_reg;
  assign rdata_next = !cpu_rd_in ? cpu_rdata_out :
                      cpu_sel_system_in ? (cpu_addr0_in ? sys_mask : sys_status) :
                      cpu_sel_local_in ? (cpu_addr0_in ? loc_mask : loc_status) : 8'h00;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      db_state_reg <= DB_IDLE;
      timer_reg <= '0;
      captured_reg <= 1'b0;
      panel_request_out <= LATCH_RESET;
      group_select_out <= 1'b1;
      cascade_enable_out <= 1'b0;
      interrupt_acknowledge_n_prev_reg <= 1'b1;
      ack_count_reg <= ACK_COUNT_RESET;
      svc_vec_reg <= 3'h0;
      ack_data_out <= 8'h00;
      ack_data_drive_out <= 1'b0;
      int_request_out <= 1'b0;
      rsel_reg <= RSEL_IRR;
      poll_armed_reg <= 1'b0;
      cpu_rdata_out <= 8'h00;
    end
    else
    begin
      db_state_reg <= db_state_next;
      timer_reg <= timer_next;
      captured_reg <= captured_next;
      panel_request_out <= latch_next;
      group_select_out <= !any_active;
      cascade_enable_out <= any_active;
      interrupt_acknowledge_n_prev_reg <= interrupt_acknowledge_n_in;
      ack_count_reg <= ack_count_next;
      if (ack_first)
      begin
        svc_vec_reg <= sys_pend_code;
      end
      ack_data_out <= ack_data_next;
      ack_data_drive_out <= ack_drive_next;
      int_request_out <= sys_pend;
      rsel_reg <= rsel_next;
      poll_armed_reg <= poll_armed_next;
      cpu_rdata_out <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_switch_drives_select: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    any_active |=> (!group_select_out && cascade_enable_out))
    else $error("select outputs wrong while a switch is active");

  chk_lowest_switch_wins: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (panel_en && panel_switch_in[0]) |=> panel_request_out[0])
    else $error("lowest numbered switch not captured");

  chk_press_starts_long: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (db_state_reg == DB_IDLE && any_active) |=> (db_state_reg == DB_LONG))
    else $error("press did not start long timer");

  chk_short_needs_switch: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (db_state_reg == DB_LONG && timer_done && !any_active) |=> (db_state_reg == DB_IDLE))
    else $error("short timer started without active switch");

  chk_short_timer_length: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(db_state_reg == DB_SHORT) |-> ##[1:SHORT_WAIT] (db_state_reg == DB_HOLD))
    else $error("short timer did not expire in time");

  chk_capture_sets_bit: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    panel_en |=> panel_request_out[$past(switch_code)])
    else $error("capture did not set addressed bit");

  chk_ack_clears_bit: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (ack_second && phase_one_clk_in && data_bus_in_strobe_in) |=> !panel_request_out[$past(ack_code)])
    else $error("serviced bit not cleared");

  chk_vector_code_bits: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (ack_count_reg == 2'h2 && ack_drive_next) |=> (ack_data_out[5:3] == $past(svc_vec_reg)))
    else $error("vector low byte lacks service code");

  chk_panel_raises_int: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ((|(panel_request_out & ~sys_mask)) && sys_isr == 8'h00) |=> int_request_out)
    else $error("panel request did not reach processor");

  chk_debounce_returns_idle: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (db_state_reg == DB_HOLD && !any_active) |=> (db_state_reg == DB_IDLE && !captured_reg))
    else $error("debounce did not return to idle");

endmodule

// [rtl/pirl_pkg.sv]
// Constants, types and shared decode for the panel interrupt request latch
package pirl_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int LONG_DEBOUNCE_MS = 10;
  localparam int LONG_DEBOUNCE_CYCLES = LONG_DEBOUNCE_MS * CLK_MHZ * 1000;
  localparam int SHORT_DEBOUNCE_NS = 500;
  localparam int SHORT_DEBOUNCE_CYCLES = (SHORT_DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMER_W = 21;

  // ---------------------------------------------------------------
  // Lines, vectors and commands
  // ---------------------------------------------------------------
  localparam int NUM_LINES = 8;
  localparam int LOCAL_LINES = 7;
  localparam logic [2:0] CASCADE_LINE = 3'h7;
  localparam int VEC_CODE_LSB = 3;
  localparam int VEC_CODE_MSB = 5;
  // Opcode, base bits and high byte of the call are arbitrary defaults
  localparam logic [7:0] CALL_OPCODE = 8'hCD;
  localparam logic [1:0] VEC_BASE_BITS = 2'h0;
  localparam logic [7:0] VEC_HIGH_BYTE = 8'h00;
  localparam logic [7:0] CMD_EOI = 8'h20;
  localparam logic [7:0] CMD_READ_IRR = 8'h0A;
  localparam logic [7:0] CMD_READ_ISR = 8'h0B;
  localparam logic [7:0] CMD_POLL = 8'h0C;
  localparam logic [7:0] CMD_READ_SVC = 8'h0D;
  localparam int POLL_VALID_BIT = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SYS_MASK_RESET = 8'h00;
  localparam logic [7:0] LOCAL_MASK_RESET = 8'h80;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [1:0] ACK_COUNT_RESET = 2'h0;

  typedef enum logic [3:0] {
    DB_IDLE  = 4'b0001,
    DB_LONG  = 4'b0010,
    DB_SHORT = 4'b0100,
    DB_HOLD  = 4'b1000
  } pirl_db_state_t;

  typedef enum logic [2:0] {
    RSEL_IRR = 3'b001,
    RSEL_ISR = 3'b010,
    RSEL_SVC = 3'b100
  } pirl_rsel_t;

  // Index of the lowest set bit; line 0 has the highest priority
  function automatic logic [2:0] pirl_prio(input logic [7:0] v);
    logic [2:0] code;
    code = 3'h7;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
      begin
        code = 3'(i);
      end
    end
    return code;
  endfunction

endpackage

// [rtl/pirl_nest_ctrl.sv]
// Fully nested eight line interrupt controller core with mask
`timescale 1ns/1ps
module pirl_nest_ctrl
  import pirl_pkg::*;
#(
  parameter logic [7:0] MASK_INIT = SYS_MASK_RESET
)
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [7:0] req_in,
  input wire logic mask_wr_in,
  input wire logic [7:0] mask_data_in,
  input wire logic eoi_in,
  input wire logic grant_in,
  output logic pend_out,
  output logic [2:0] pend_code_out,
  output logic [2:0] svc_code_out,
  output logic [7:0] isr_out,
  output logic [7:0] mask_out,
  output logic [7:0] irr_out
);

  logic [7:0] mask_reg;
  logic [7:0] isr_reg;
  logic [7:0] isr_next;
  logic [7:0] eligible;
  logic [7:0] grant_bit;
  logic [7:0] eoi_bit;
  logic svc_any;

  assign eligible = req_in & ~mask_reg;
  assign pend_code_out = pirl_prio(eligible);
  assign svc_code_out = pirl_prio(isr_reg);
  assign svc_any = |isr_reg;
  // A higher request may pre-empt the one in service
  assign pend_out = (|eligible) && (!svc_any || (pend_code_out < svc_code_out));
  assign grant_bit = (grant_in && pend_out) ? (8'h01 << pend_code_out) : 8'h00;
  assign eoi_bit = (eoi_in && svc_any) ? (8'h01 << svc_code_out) : 8'h00;
  // A grant in the same cycle as an end of service is kept
  assign isr_next = (isr_reg & ~eoi_bit) | grant_bit;
  assign isr_out = isr_reg;
  assign mask_out = mask_reg;
  assign irr_out = req_in;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mask_reg <= MASK_INIT;
      isr_reg <= 8'h00;
    end
    else
    begin
      if (mask_wr_in)
      begin
        mask_reg <= mask_data_in;
      end
      isr_reg <= isr_next;
    end
  end

  chk_grant_marks_service: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (grant_in && pend_out) |=> isr_reg[$past(pend_code_out)])
    else $error("granted request not marked in service");

  chk_mask_write_takes: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    mask_wr_in |=> (mask_reg == $past(mask_data_in)))
    else $error("mask write not stored");

endmodule

// [sim/pirl_cpu_model.sv]
// Processor side model: phase one clock and acknowledge cycles
`timescale 1ns/1ps
module pirl_cpu_model
  import pirl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic [7:0] ack_data_in,
  input wire logic ack_drive_in,
  output logic phase_one_clk_out,
  output logic interrupt_acknowledge_n_out,
  output logic data_bus_in_strobe_out
);
  // ---------------------------------------------------------------
  // Phase one clock, high one cycle in four
  // ---------------------------------------------------------------
  logic [1:0] ph_cnt_reg = 2'h0;
  always @(negedge clk_sys_in)
  begin
    ph_cnt_reg <= ph_cnt_reg + 2'h1;
  end
  assign phase_one_clk_out = (ph_cnt_reg == 2'h0);
  initial
  begin
    interrupt_acknowledge_n_out = 1'b1;
    data_bus_in_strobe_out = 1'b0;
  end
  // ---------------------------------------------------------------
  // Acknowledge sequence
  // ---------------------------------------------------------------
  // Strobe spans a phase one pulse, else the clear never lands
  // Vector spacing stays 8; spacing 4 is never programmed
  task automatic ack_seq(output logic [2:0][7:0] b);
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clk_sys_in);
      interrupt_acknowledge_n_out = 1'b0;
      data_bus_in_strobe_out = 1'b1;
      repeat (6) @(negedge clk_sys_in);
      // A byte not marked as driven reads as unknown and fails the compare
      b[i] = ack_drive_in ? ack_data_in : 8'hXX;
      interrupt_acknowledge_n_out = 1'b1;
      data_bus_in_strobe_out = 1'b0;
      repeat (2) @(negedge clk_sys_in);
    end
  endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the panel interrupt request latch
`timescale 1ns/1ps
module tb;
  import pirl_pkg::*;
  // Short long-timer so a press takes cycles, not milliseconds
  localparam int LONG = 20;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] panel_switch_in = 8'h00;
  logic phase_one_clk_in;
  logic [7:0] bus_request_lines_n_in = 8'hFF;
  logic [6:0] local_request_in = 7'h00;
  logic interrupt_acknowledge_n_n;
  logic strobe;
  logic cpu_wr_in = 1'b0;
  logic cpu_rd_in = 1'b0;
  logic cpu_sel_system_in = 1'b0;
  logic cpu_sel_local_in = 1'b0;
  logic cpu_addr0_in = 1'b0;
  logic [7:0] cpu_wdata_in = 8'h00;
  logic group_select_out;
  logic cascade_enable_out;
  logic [7:0] panel_request_out;
  logic int_request_out;
  logic [7:0] ack_data_out;
  logic ack_data_drive_out;
  logic [7:0] cpu_rdata_out;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  pirl_top #(.LONG_CYCLES(LONG)) pirl_top_inst (
    .clk_sys_in, .reset_n_in, .panel_switch_in, .phase_one_clk_in,
    .bus_request_lines_n_in, .local_request_in,
    .interrupt_acknowledge_n_in(interrupt_acknowledge_n_n), .data_bus_in_strobe_in(strobe),
    .cpu_wr_in, .cpu_rd_in, .cpu_sel_system_in, .cpu_sel_local_in,
    .cpu_addr0_in, .cpu_wdata_in, .group_select_out, .cascade_enable_out,
    .panel_request_out, .int_request_out, .ack_data_out,
    .ack_data_drive_out, .cpu_rdata_out
  );

  pirl_cpu_model pirl_cpu_model_inst (
    .clk_sys_in, .ack_data_in(ack_data_out), .phase_one_clk_out(phase_one_clk_in),
    .interrupt_acknowledge_n_out(interrupt_acknowledge_n_n), .data_bus_in_strobe_out(strobe),
    .ack_drive_in(ack_data_drive_out)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  function automatic logic [2:0] low_code(input logic [7:0] v);
    logic [2:0] c;
    c = 3'h7;
    for (int i = 7; i >= 0; i--)
      if (v[i])
        c = 3'(i);
    return c;
  endfunction

  task automatic cpu_bus(input logic wr, input logic loc, input logic a0, input logic [7:0] d);
    @(negedge clk_sys_in);
    cpu_wr_in = wr;
    cpu_rd_in = !wr;
    cpu_sel_system_in = !loc;
    cpu_sel_local_in = loc;
    cpu_addr0_in = a0;
    cpu_wdata_in = d;
    @(negedge clk_sys_in);
    cpu_wr_in = 1'b0;
    cpu_rd_in = 1'b0;
    cpu_sel_system_in = 1'b0;
    cpu_sel_local_in = 1'b0;
  endtask

  task automatic cpu_rd(input logic loc, input logic a0, output logic [7:0] d);
    cpu_bus(1'b0, loc, a0, 8'h00);
    @(negedge clk_sys_in);
    d = cpu_rdata_out;
  endtask

  task automatic press(input logic [7:0] sw, input int hold);
    @(negedge clk_sys_in);
    panel_switch_in = sw;
    wait_n(3);
    check("group_select", 8'h00, 8'(group_select_out));
    check("cascade_enable", 8'h01, 8'(cascade_enable_out));
    wait_n(hold);
    panel_switch_in = 8'h00;
    wait_n(LONG + 130);
  endtask

  task automatic ack(input logic [2:0] c);
    logic [2:0][7:0] b;
    pirl_cpu_model_inst.ack_seq(b);
    check("ack_opcode", CALL_OPCODE, b[0]);
    check("ack_vector", {VEC_BASE_BITS, c, 3'h0}, b[1]);
    check("ack_high", VEC_HIGH_BYTE, b[2]);
    check("ack_drive_idle", 8'h00, 8'(ack_data_drive_out));
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [7:0] sw;
    logic [7:0] rd;
    logic [2:0] c;
    int k;
    void'($urandom(44));
    wait_n(5);
    reset_n_in = 1'b1;
    check("reset_group_select", 8'h01, 8'(group_select_out));
    check("reset_latch", LATCH_RESET, panel_request_out);
    // A bounce shorter than the long timer must leave no request
    press(8'h04, LONG / 2);
    check("short_press", 8'h00, panel_request_out);
    for (int n = 0; n < 4; n++)
    begin
      sw = (n == 0) ? 8'hFF : (n == 1) ? 8'h40 : 8'($urandom_range(1, 127));
      c = low_code(sw);
      press(sw, LONG + 130);
      check("latch_set", 8'h01 << c, panel_request_out);
      check("int_request", 8'h01, 8'(int_request_out));
      ack(c);
      check("latch_clear", 8'h00, panel_request_out);
      cpu_bus(1'b1, 1'b0, 1'b0, CMD_EOI);
    end
    k = $urandom_range(0, LOCAL_LINES - 1);
    local_request_in = 7'(1 << k);
    wait_n(4);
    check("local_cascade", 8'h01, 8'(int_request_out));
    cpu_bus(1'b1, 1'b1, 1'b0, CMD_POLL);
    cpu_rd(1'b1, 1'b0, rd);
    check("local_poll", {1'b1, 4'h0, 3'(k)}, rd);
    local_request_in = 7'h00;
    cpu_bus(1'b1, 1'b1, 1'b0, CMD_EOI);
    cpu_bus(1'b1, 1'b0, 1'b1, 8'hFF);
    cpu_rd(1'b0, 1'b1, rd);
    check("mask_read", 8'hFF, rd);
    bus_request_lines_n_in = 8'hD7;
    wait_n(4);
    check("masked_request", 8'h00, 8'(int_request_out));
    cpu_bus(1'b1, 1'b0, 1'b1, 8'h00);
    wait_n(4);
    check("bus_request", 8'h01, 8'(int_request_out));
    ack(3'h3);
    wait_n(3);
    check("nested_hold", 8'h00, 8'(int_request_out));
    bus_request_lines_n_in = 8'hD5;
    wait_n(3);
    check("preempt", 8'h01, 8'(int_request_out));
    cpu_bus(1'b1, 1'b0, 1'b0, CMD_READ_IRR);
    cpu_rd(1'b0, 1'b0, rd);
    check("pending", 8'h2A, rd);
    bus_request_lines_n_in = 8'hFF;
    cpu_bus(1'b1, 1'b0, 1'b0, CMD_READ_ISR);
    cpu_rd(1'b0, 1'b0, rd);
    check("in_service", 8'h08, rd);
    cpu_bus(1'b1, 1'b0, 1'b0, CMD_READ_SVC);
    cpu_rd(1'b0, 1'b0, rd);
    check("service_code", 8'h03, rd);
    test_done;
  end

  // Hang guard, well above the roughly 1600 cycles the run needs
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      test_done;
    end
  end
endmodule
